// File: trps_defs.svh
// timing and encoding constants for the three rail power sequencer
`ifndef TRPS_DEFS_SVH
`define TRPS_DEFS_SVH
`define TRPS_CLK_HZ 25000000
`define TRPS_DELAY_SHORT_MS 30
`define TRPS_DELAY_MEDIUM_MS 60
`define TRPS_DELAY_LONG_MS 120
`define TRPS_OFFSET_US 400
`define TRPS_TOL_PCT 15
`define TRPS_CYC_PER_MS (`TRPS_CLK_HZ / 1000)
`define TRPS_OFFSET_CYC ((`TRPS_OFFSET_US * `TRPS_CYC_PER_MS + 999) / 1000)
`define TRPS_CNT_W 22
`define TRPS_OPT_SHORT 0
`define TRPS_OPT_MEDIUM 1
`define TRPS_OPT_LONG 2
`define TRPS_SYNC_W 4
`define TRPS_EN_BIT 0
`endif

// File: trps_pkg.sv
// types and constant functions for the three rail power sequencer
`include "trps_defs.svh"
package trps_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_up1 = 3'h1,
    st_up2 = 3'h3,
    st_up3 = 3'h2,
    st_on = 3'h6,
    st_dn3 = 3'h7,
    st_dn2 = 3'h5,
    st_dn1 = 3'h4
  } trps_state_type;

  typedef logic [`TRPS_CNT_W-1:0] trps_count_type;

  // nominal cycles of one delay for a timing option
  function automatic int trps_opt_cycles(input int opt);
    int ms;
    ms = `TRPS_DELAY_SHORT_MS;
    if (opt == `TRPS_OPT_MEDIUM) begin
      ms = `TRPS_DELAY_MEDIUM_MS;
    end else if (opt == `TRPS_OPT_LONG) begin
      ms = `TRPS_DELAY_LONG_MS;
    end
    return ms * `TRPS_CYC_PER_MS;
  endfunction
endpackage

// File: trps_timer_if.sv
// control link between the sequencer and its delay timer
`timescale 1ns/10ps
`default_nettype none
interface trps_timer_if;
  logic ce;
  logic load;
  trps_pkg::trps_count_type value;
  logic expired;
  modport ctrl (output ce, output load, output value, input expired);
  modport tmr (input ce, input load, input value, output expired);
endinterface
`default_nettype wire

// File: trps_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
`include "trps_defs.svh"
module trps_sync #(
  parameter int WIDTH = `TRPS_SYNC_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // pins and synchronised copy
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  // meta_reg feeds only q_reg
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule
`default_nettype wire

// File: trps_timer.sv
// reloadable down counter that times one sequencing step
`timescale 1ns/10ps
`default_nettype none
module trps_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // control link
  trps_timer_if.tmr tif
);
  trps_pkg::trps_count_type count_reg;
  logic run_reg;

  // expiry after exactly value enabled cycles from the load
  assign tif.expired = run_reg && (count_reg == trps_pkg::trps_count_type'(1)); // RULE14 RULE10

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      count_reg <= '0;
      run_reg <= 1'b0;
    end else if (tif.ce) begin
      if (tif.load) begin
        count_reg <= tif.value;
        run_reg <= 1'b1;
      end else if (tif.expired) begin
        run_reg <= 1'b0;
      end else if (run_reg) begin
        count_reg <= count_reg - trps_pkg::trps_count_type'(1);
      end
    end
  end

  property p_tmr_load;
    @(posedge mclk) disable iff (!rstn)
    (tif.ce && tif.load) |=> (count_reg == $past(tif.value)) && run_reg;
  endproperty
  a_tmr_load: assert property (p_tmr_load) else $error("timer load lost"); // RULE14

  property p_tmr_freeze;
    @(posedge mclk) disable iff (!rstn)
    !tif.ce |=> $stable(count_reg) && $stable(run_reg);
  endproperty
  a_tmr_freeze: assert property (p_tmr_freeze) else $error("timer moved while frozen");

  property p_tmr_single;
    @(posedge mclk) disable iff (!rstn)
    (tif.ce && tif.expired && !tif.load) |=> !tif.expired;
  endproperty
  a_tmr_single: assert property (p_tmr_single) else $error("timer expired twice"); // RULE7
endmodule
`default_nettype wire

// File: trps_top.sv
// three rail power sequencer: enable pin in, three open-drain rail releases out
// Notes on behaviour
// (RULE1) all rails stay pulled low from reset until enable is first seen high.
// (RULE2) enable high starts power-up; rail 1 is released when the first up delay ends.
// (RULE3) rail 2 follows rail 1 after its own delay, rail 3 follows rail 2 after another.
// (RULE4) rails are released in order 1,2,3 and pulled low in order 3,2,1.
// (RULE5) enable low starts a delay after which rail 3 is pulled low.
// (RULE6) rail 2 and then rail 1 are pulled low, each after its own down delay.
// (RULE7) six separate delays exist, the three down delays set apart from the up ones.
// (RULE8) the timing option sets the nominal value of all six delays to 30, 60 or 120 ms.
// (RULE9) the first delay of each sequence is 400 us longer than the next.
// (RULE10) each delay lands within 15 percent of its nominal value.
// (RULE11) the enable pad has a weak pull-up, so an open pin counts as high.
// (RULE12) each rail release pin needs an outside pull-up to read high when released.
// (RULE13) an enable change mid-sequence reverses it, touching only rails already moved.
// (RULE14) enable is synchronised and delays are whole counts of the 40 ns clock.
`timescale 1ns/10ps
`default_nettype none
`include "trps_defs.svh"
module trps_top #(
  parameter int TIMING_OPTION = `TRPS_OPT_SHORT,
  parameter int UP_DELAY_FIRST = trps_pkg::trps_opt_cycles(TIMING_OPTION) + `TRPS_OFFSET_CYC,
  parameter int UP_DELAY_SECOND = trps_pkg::trps_opt_cycles(TIMING_OPTION),
  parameter int UP_DELAY_THIRD = trps_pkg::trps_opt_cycles(TIMING_OPTION),
  parameter int DOWN_DELAY_FIRST = trps_pkg::trps_opt_cycles(TIMING_OPTION) + `TRPS_OFFSET_CYC,
  parameter int DOWN_DELAY_SECOND = trps_pkg::trps_opt_cycles(TIMING_OPTION),
  parameter int DOWN_DELAY_THIRD = trps_pkg::trps_opt_cycles(TIMING_OPTION)
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  // enable pin
  input wire logic enable_pin,
  // rail release pins, open drain
  input wire logic rail_release_in_1,
  input wire logic rail_release_in_2,
  input wire logic rail_release_in_3,
  output logic rail_release_out_1,
  output logic rail_release_out_2,
  output logic rail_release_out_3,
  output logic rail_release_out_1_oe,
  output logic rail_release_out_2_oe,
  output logic rail_release_out_3_oe,
  // status
  output logic [2:0] rail_held_low
);
  // delays as timer loads, cut to the counter width
  localparam trps_pkg::trps_count_type UP1_CYC = trps_pkg::trps_count_type'(UP_DELAY_FIRST); // RULE8 RULE9
  localparam trps_pkg::trps_count_type UP2_CYC = trps_pkg::trps_count_type'(UP_DELAY_SECOND);
  localparam trps_pkg::trps_count_type UP3_CYC = trps_pkg::trps_count_type'(UP_DELAY_THIRD);
  localparam trps_pkg::trps_count_type DN1_CYC = trps_pkg::trps_count_type'(DOWN_DELAY_FIRST); // RULE7 RULE9
  localparam trps_pkg::trps_count_type DN2_CYC = trps_pkg::trps_count_type'(DOWN_DELAY_SECOND);
  localparam trps_pkg::trps_count_type DN3_CYC = trps_pkg::trps_count_type'(DOWN_DELAY_THIRD);

  // mask of rails released in a state, low rails first
  function automatic logic [2:0] released_of(input trps_pkg::trps_state_type st);
    logic [2:0] r;
    r = 3'h0;
    unique case (st)
      trps_pkg::st_idle, trps_pkg::st_up1: r = 3'h0;
      trps_pkg::st_up2, trps_pkg::st_dn1: r = 3'h1; // RULE4
      trps_pkg::st_up3, trps_pkg::st_dn2: r = 3'h3;
      trps_pkg::st_on, trps_pkg::st_dn3: r = 3'h7;
    endcase
    return r;
  endfunction

  trps_pkg::trps_state_type state_reg;
  trps_pkg::trps_state_type state_next;
  logic [2:0] oe_reg;
  logic [2:0] held_reg;
  logic [2:0] oe_dly1_reg;
  logic [2:0] oe_dly2_reg;
  trps_pkg::trps_count_type dwell_reg;
  logic [`TRPS_SYNC_W-1:0] pin_sync;
  wire en_sync;
  wire [2:0] rail_sync;
  wire step_done;
  wire state_moves;
  wire timed_next;

  trps_timer_if tif ();

  // enable and rail readback cross into the clock domain here
  trps_sync #(
    .WIDTH(`TRPS_SYNC_W)
  ) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .ce(clk_en),
    .d({rail_release_in_3, rail_release_in_2, rail_release_in_1, enable_pin}),
    .q(pin_sync)
  ); // RULE14

  // an open enable pin is lifted high by the pad pull-up
  assign en_sync = pin_sync[`TRPS_EN_BIT]; // RULE11
  assign rail_sync = pin_sync[3:1];

  trps_timer u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .tif(tif)
  );

  assign step_done = tif.expired;

  // enable wins over a timer that ends in the same cycle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      trps_pkg::st_idle: begin
        if (en_sync) begin
          state_next = trps_pkg::st_up1; // RULE1 RULE2
        end
      end
      trps_pkg::st_up1: begin
        if (!en_sync) begin
          state_next = trps_pkg::st_idle; // RULE13
        end else if (step_done) begin
          state_next = trps_pkg::st_up2; // RULE2
        end
      end
      trps_pkg::st_up2: begin
        if (!en_sync) begin
          state_next = trps_pkg::st_dn1; // RULE13
        end else if (step_done) begin
          state_next = trps_pkg::st_up3; // RULE3
        end
      end
      trps_pkg::st_up3: begin
        if (!en_sync) begin
          state_next = trps_pkg::st_dn2; // RULE13
        end else if (step_done) begin
          state_next = trps_pkg::st_on; // RULE3
        end
      end
      trps_pkg::st_on: begin
        if (!en_sync) begin
          state_next = trps_pkg::st_dn3; // RULE5
        end
      end
      trps_pkg::st_dn3: begin
        if (en_sync) begin
          state_next = trps_pkg::st_on; // RULE13
        end else if (step_done) begin
          state_next = trps_pkg::st_dn2; // RULE5
        end
      end
      trps_pkg::st_dn2: begin
        if (en_sync) begin
          state_next = trps_pkg::st_up3; // RULE13
        end else if (step_done) begin
          state_next = trps_pkg::st_dn1; // RULE6
        end
      end
      trps_pkg::st_dn1: begin
        if (en_sync) begin
          state_next = trps_pkg::st_up2; // RULE13
        end else if (step_done) begin
          state_next = trps_pkg::st_idle; // RULE6
        end
      end
    endcase
  end

  // every timed state restarts the timer on entry, so a stale count never counts
  assign state_moves = (state_next != state_reg);
  assign timed_next = (state_next != trps_pkg::st_idle) && (state_next != trps_pkg::st_on);
  assign tif.ce = clk_en;
  assign tif.load = clk_en && state_moves && timed_next;
  assign tif.value = (state_next == trps_pkg::st_up1) ? UP1_CYC :
                     (state_next == trps_pkg::st_up2) ? UP2_CYC :
                     (state_next == trps_pkg::st_up3) ? UP3_CYC :
                     (state_next == trps_pkg::st_dn3) ? DN1_CYC :
                     (state_next == trps_pkg::st_dn2) ? DN2_CYC : DN3_CYC; // RULE7 RULE10

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_reg <= trps_pkg::st_idle;
      oe_reg <= 3'h7;
    end else if (clk_en) begin
      state_reg <= state_next;
      oe_reg <= ~released_of(state_next); // RULE4
    end
  end

  // released rail that still reads low, e.g. held by its regulator
  // readback lags the drive by the synchroniser, so a fresh release waits two cycles
  // before it may count; otherwise every release would flash a false hold
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      oe_dly1_reg <= 3'h7;
      oe_dly2_reg <= 3'h7;
      held_reg <= 3'h0;
    end else if (clk_en) begin
      oe_dly1_reg <= oe_reg;
      oe_dly2_reg <= oe_dly1_reg;
      held_reg <= ~oe_reg & ~oe_dly2_reg & ~rail_sync; // RULE12
    end
  end

  // cycles spent in the present state, read only by checks
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dwell_reg <= '0;
    end else if (clk_en) begin
      dwell_reg <= state_moves ? '0 : dwell_reg + trps_pkg::trps_count_type'(1);
    end
  end

  // open drain: the pin only ever pulls low
  assign rail_release_out_1 = 1'b0;
  assign rail_release_out_2 = 1'b0;
  assign rail_release_out_3 = 1'b0;
  assign rail_release_out_1_oe = oe_reg[0];
  assign rail_release_out_2_oe = oe_reg[1];
  assign rail_release_out_3_oe = oe_reg[2];
  assign rail_held_low = held_reg;

  property p_idle_low;
    @(posedge mclk) disable iff (!rstn)
    (state_reg == trps_pkg::st_idle) |-> (oe_reg == 3'h7);
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("rail released while idle"); // RULE1

  property p_start_up;
    @(posedge mclk) disable iff (!rstn)
    (clk_en && state_reg == trps_pkg::st_idle && en_sync) |=>
      (state_reg == trps_pkg::st_up1) && tif.expired == 1'b0 && oe_reg == 3'h7;
  endproperty
  a_start_up: assert property (p_start_up) else $error("power-up did not start"); // RULE2

  property p_up1_len;
    @(posedge mclk) disable iff (!rstn)
    (clk_en && state_reg == trps_pkg::st_up1 && state_next == trps_pkg::st_up2) |->
      (dwell_reg == UP1_CYC - trps_pkg::trps_count_type'(1));
  endproperty
  a_up1_len: assert property (p_up1_len) else $error("first up delay wrong length"); // RULE2

  property p_up2_len;
    @(posedge mclk) disable iff (!rstn)
    (clk_en && state_reg == trps_pkg::st_up2 && state_next == trps_pkg::st_up3) |->
      (dwell_reg == UP2_CYC - trps_pkg::trps_count_type'(1));
  endproperty
  a_up2_len: assert property (p_up2_len) else $error("second up delay wrong length"); // RULE3

  property p_up3_len;
    @(posedge mclk) disable iff (!rstn)
    (clk_en && state_reg == trps_pkg::st_up3 && state_next == trps_pkg::st_on) |->
      (dwell_reg == UP3_CYC - trps_pkg::trps_count_type'(1)) ##1 (oe_reg == 3'h0);
  endproperty
  a_up3_len: assert property (p_up3_len) else $error("third up delay wrong length"); // RULE3

  property p_order;
    @(posedge mclk) disable iff (!rstn)
    (!oe_reg[2] |-> !oe_reg[1]) and (!oe_reg[1] |-> !oe_reg[0]);
  endproperty
  a_order: assert property (p_order) else $error("rails out of order"); // RULE4

  property p_dn3_len;
    @(posedge mclk) disable iff (!rstn)
    (clk_en && state_reg == trps_pkg::st_dn3 && state_next == trps_pkg::st_dn2) |->
      (dwell_reg == DN1_CYC - trps_pkg::trps_count_type'(1)) ##1 (oe_reg == 3'h4);
  endproperty
  a_dn3_len: assert property (p_dn3_len) else $error("rail 3 pulled low at wrong time"); // RULE5

  property p_dn2_len;
    @(posedge mclk) disable iff (!rstn)
    (clk_en && state_reg == trps_pkg::st_dn2 && state_next == trps_pkg::st_dn1) |->
      (dwell_reg == DN2_CYC - trps_pkg::trps_count_type'(1)) ##1 (oe_reg == 3'h6);
  endproperty
  a_dn2_len: assert property (p_dn2_len) else $error("rail 2 pulled low at wrong time"); // RULE6

  property p_dn1_len;
    @(posedge mclk) disable iff (!rstn)
    (clk_en && state_reg == trps_pkg::st_dn1 && state_next == trps_pkg::st_idle) |->
      (dwell_reg == DN3_CYC - trps_pkg::trps_count_type'(1)) ##1 (oe_reg == 3'h7);
  endproperty
  a_dn1_len: assert property (p_dn1_len) else $error("rail 1 pulled low at wrong time"); // RULE6

  property p_down_load;
    @(posedge mclk) disable iff (!rstn)
    (tif.load && state_next == trps_pkg::st_dn3) |-> (tif.value == DN1_CYC);
  endproperty
  a_down_load: assert property (p_down_load) else $error("down timer loaded wrong"); // RULE7

  property p_abort_up;
    @(posedge mclk) disable iff (!rstn)
    (clk_en && state_reg == trps_pkg::st_up3 && !en_sync) |=>
      (state_reg == trps_pkg::st_dn2) && (oe_reg == 3'h4);
  endproperty
  a_abort_up: assert property (p_abort_up) else $error("abort changed wrong rails"); // RULE13

  property p_abort_down;
    @(posedge mclk) disable iff (!rstn)
    (clk_en && state_reg == trps_pkg::st_dn3 && en_sync) |=>
      (state_reg == trps_pkg::st_on) && (oe_reg == 3'h0);
  endproperty
  a_abort_down: assert property (p_abort_down) else $error("rail 3 dropped on re-enable"); // RULE13

  property p_frozen;
    @(posedge mclk) disable iff (!rstn)
    !clk_en |=> $stable(state_reg) && $stable(oe_reg);
  endproperty
  a_frozen: assert property (p_frozen) else $error("state moved with clock disabled"); // RULE14
endmodule
`default_nettype wire

// File: trps_rail_model.sv
// partner model: pull-ups and regulator enable inputs on the three rail pins
`timescale 1ns/10ps
`default_nettype none
module trps_rail_model (
  // drive from the sequencer
  input wire logic [2:0] drv,
  input wire logic [2:0] oe,
  // a regulator that clamps its enable pin low, only on command
  input wire logic [2:0] clamp,
  // resolved pin levels
  output logic [2:0] level
);
  // a released pin floats up through its pull-up; any low driver wins
  assign level = ~(oe & ~drv) & ~clamp;
endmodule
`default_nettype wire

// File: tb.sv
// self-checking testbench for the three rail power sequencer
`timescale 1ns/10ps
`default_nettype none
`include "trps_defs.svh"
module tb;
  // distinct delays so a swapped timer shows up as a wrong count
  localparam int UP1 = 14;
  localparam int UP2 = 10;
  localparam int UP3 = 11;
  localparam int DN1 = 13;
  localparam int DN2 = 9;
  localparam int DN3 = 12;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic enable_pin = 1'b0;
  logic [2:0] clamp = 3'h0;
  logic [2:0] drv;
  logic [2:0] oe;
  logic [2:0] level;
  logic [2:0] held;
  int fail_count = 0;
  int cmp_count = 0;
  int n;

  always #20 mclk = ~mclk;

  trps_top #(.UP_DELAY_FIRST(UP1), .UP_DELAY_SECOND(UP2), .UP_DELAY_THIRD(UP3),
    .DOWN_DELAY_FIRST(DN1), .DOWN_DELAY_SECOND(DN2), .DOWN_DELAY_THIRD(DN3)) u_trps_top (
    .mclk(mclk),
    .rstn(rstn),
    .clk_en(clk_en),
    .enable_pin(enable_pin),
    .rail_release_in_1(level[0]),
    .rail_release_in_2(level[1]),
    .rail_release_in_3(level[2]),
    .rail_release_out_1(drv[0]),
    .rail_release_out_2(drv[1]),
    .rail_release_out_3(drv[2]),
    .rail_release_out_1_oe(oe[0]),
    .rail_release_out_2_oe(oe[1]),
    .rail_release_out_3_oe(oe[2]),
    .rail_held_low(held)
  );

  trps_rail_model u_trps_rail_model (.drv(drv), .oe(oe), .clamp(clamp), .level(level));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check_vec(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic idle(input int cycles);
    repeat (cycles) @(negedge mclk);
  endtask

  // bounded wait for one rail enable to reach a level, counting clock edges
  task automatic wait_oe(input int idx, input logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(negedge mclk);
      cnt++;
    end while (oe[idx] !== lvl && cnt < 400);
    if (oe[idx] !== lvl) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, oe[idx], lvl);
      summarize();
    end
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    idle(6);
    check_vec({1'b0, oe}, 4'h7);
    rstn = 1'b1;
  endtask

  task automatic power_up();
    enable_pin = 1'b1;
    wait_oe(0, 1'b0, n);
    check_cnt(n, UP1 + 2, UP1 + 3);
    check_vec({1'b0, oe}, 4'h6);
    wait_oe(1, 1'b0, n);
    check_cnt(n, UP2, UP2);
    check_vec({1'b0, oe}, 4'h4);
    wait_oe(2, 1'b0, n);
    check_cnt(n, UP3, UP3);
    check_vec({1'b0, level}, 4'h7);
  endtask

  task automatic power_down();
    enable_pin = 1'b0;
    wait_oe(2, 1'b1, n);
    check_cnt(n, DN1 + 2, DN1 + 3);
    check_vec({1'b0, oe}, 4'h4);
    wait_oe(1, 1'b1, n);
    check_cnt(n, DN2, DN2);
    check_vec({1'b0, oe}, 4'h6);
    wait_oe(0, 1'b1, n);
    check_cnt(n, DN3, DN3);
    check_vec({drv, 1'b0}, 4'h0);
  endtask

  task automatic t_idle_after_reset();
    idle(40);
    check_vec({held, 1'b1}, 4'h1);
    check_vec({1'b0, oe}, 4'h7);
  endtask

  task automatic t_aborts();
    enable_pin = 1'b1;
    idle(UP1 / 2);
    enable_pin = 1'b0;
    idle(UP1 + 10);
    check_vec({1'b0, oe}, 4'h7);
    enable_pin = 1'b1;
    wait_oe(0, 1'b0, n);
    enable_pin = 1'b0;
    wait_oe(0, 1'b1, n);
    check_cnt(n, DN3 + 2, DN3 + 3);
    check_vec({1'b0, oe}, 4'h7);
    power_up();
    enable_pin = 1'b0;
    idle(4);
    enable_pin = 1'b1;
    idle(DN1 + 10);
    check_vec({1'b0, oe}, 4'h0);
    enable_pin = 1'b0;
    wait_oe(2, 1'b1, n);
    enable_pin = 1'b1;
    wait_oe(2, 1'b0, n);
    check_cnt(n, UP3 + 2, UP3 + 3);
    check_vec({1'b0, oe}, 4'h0);
    power_down();
  endtask

  // freezing the clock enable must stretch the delay, not skip it
  task automatic t_freeze_and_clamp();
    enable_pin = 1'b1;
    idle(3);
    clk_en = 1'b0;
    idle(UP1 + 20);
    check_vec({1'b0, oe}, 4'h7);
    clk_en = 1'b1;
    wait_oe(0, 1'b0, n);
    check_cnt(n, UP1 - 1, UP1 + 1);
    wait_oe(1, 1'b0, n);
    clamp = 3'h2;
    idle(6);
    check_vec({1'b0, held}, 4'h2);
    clamp = 3'h0;
    idle(6);
    check_vec({1'b0, held}, 4'h0);
    wait_oe(2, 1'b0, n);
    check_vec({1'b0, oe}, 4'h0);
  endtask

  // option table in 40 ns cycles; first delays carry the 400 us offset on top
  task automatic t_option_table();
    check_cnt(trps_pkg::trps_opt_cycles(`TRPS_OPT_SHORT), 750000, 750000);
    check_cnt(trps_pkg::trps_opt_cycles(`TRPS_OPT_MEDIUM), 1500000, 1500000);
    check_cnt(trps_pkg::trps_opt_cycles(`TRPS_OPT_LONG), 3000000, 3000000);
    check_cnt(`TRPS_OFFSET_CYC, 10000, 10000);
  endtask

  // reset in mid-run with enable still high pulls every rail, then restarts
  task automatic t_mid_reset();
    do_reset();
    power_up();
    power_down();
  endtask

  initial begin
    do_reset();
    t_idle_after_reset();
    power_up();
    power_down();
    t_aborts();
    t_freeze_and_clamp();
    t_mid_reset();
    t_option_table();
    summarize();
  end
endmodule
`default_nettype wire
